//--- design/smm_regs.svh
`ifndef SMM_REGS_SVH
`define SMM_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses on the management page)
// ----------------------------------------
`define SMM_OFF_MGMT_CFG 8'h00
`define SMM_OFF_AGING 8'h0c
`define SMM_OFF_MIR_CAP 8'h10
`define SMM_OFF_IN_MIR 8'h12
`define SMM_OFF_IN_DIV 8'h16
`define SMM_OFF_EG_MIR 8'h1c
`define SMM_OFF_MODEL 8'h30
`define SMM_OFF_REV 8'h40
`define SMM_OFF_PAGE 8'hff
// ----------------------------------------
// page and field positions
// ----------------------------------------
`define SMM_MGMT_PAGE 8'h02
`define SMM_CFG_PORT_HI 7
`define SMM_CFG_PORT_LO 6
`define SMM_CFG_SNOOP_BIT 3
`define SMM_CFG_BPDU_BIT 1
`define SMM_CFG_RW_MASK 8'hca
`define SMM_PORT_SEL_IMP 2'h2
`define SMM_IGMP_PROTO 8'h02
`define SMM_MIR_EN_BIT 15
`define SMM_MIR_BLK_BIT 14
`define SMM_IN_DIV_EN_BIT 29
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SMM_AGING_RESET 20'h0012c
`define SMM_CLK_HZ 10000000
`define SMM_TICKS_PER_SEC (`SMM_CLK_HZ)
`endif

//--- design/smm_pkg.sv
package smm_pkg;
   typedef logic [4:0] smm_port_t;
   typedef enum logic [1:0] {SMM_AGE_IDLE, SMM_AGE_COUNT, SMM_AGE_SWEEP} smm_age_state_t;
endpackage

//--- design/smm_mgmt_page.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "smm_regs.svh"
module smm_mgmt_page import smm_pkg::*; #(
   parameter int NUM_PORTS = 17,
   parameter int TICKS_PER_SEC = `SMM_TICKS_PER_SEC,
   parameter logic [7:0] MODEL_CODE = 8'h5a, // arbitrary value
   parameter logic [7:0] REV_CODE = 8'h01 // arbitrary value
) (
   input wire logic sys_clk, // core clock
   input wire logic rst, // synchronous reset, high
   input wire logic [7:0] reg_addr, // register offset
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic rx_valid, // received frame classified this cycle
   input wire logic [4:0] rx_port, // ingress port of that frame
   input wire logic [7:0] rx_ip_proto, // ip protocol field
   input wire logic rx_is_ip, // frame carries an ip header
   input wire logic rx_is_bpdu, // frame is a bridge pdu
   input wire logic tx_valid, // transmitted frame this cycle
   input wire logic [4:0] tx_port, // egress port of that frame
   input wire logic [4:0] tx_dest, // normal destination of a frame
   output logic to_cpu_q, // copy this rx frame to cpu port
   output logic drop_bpdu_q, // bpdu not delivered anywhere
   output logic mirror_rx_q, // mirror this rx frame
   output logic mirror_tx_q, // mirror this tx frame
   output smm_port_t capture_port_q, // capture port for mirrors
   output logic block_dest_q, // normal frame to capture port dropped
   output logic age_tick_q, // one-cycle aging sweep pulse
   output logic aging_active // aging process running
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   // the selection masks are 17 bits wide, so more ports cannot be served
   if (NUM_PORTS < 1 || NUM_PORTS > 17) begin : g_bad_ports
      $error("NUM_PORTS out of range");
   end
   if (TICKS_PER_SEC < 1) begin : g_bad_ticks
      $error("TICKS_PER_SEC must be positive");
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] page_q;
   logic [7:0] cfg_q;
   logic [19:0] aging_q;
   logic mir_en_q;
   logic mir_blk_q;
   smm_port_t cap_q;
   logic in_div_en_q;
   logic [16:0] in_mask_q;
   logic [9:0] in_div_q;
   logic [16:0] eg_mask_q;
   logic [9:0] div_cnt_q;
   logic [31:0] tick_cnt_q;
   logic [19:0] sec_cnt_q;
   smm_age_state_t age_st_q;

   // page decode: only the page register answers on every page
   logic on_page;
   logic wr_page;
   assign on_page = (page_q == `SMM_MGMT_PAGE);
   assign wr_page = reg_wr && on_page;

   function automatic logic hit(input logic [7:0] off);
      hit = wr_page && (reg_addr == off);
   endfunction

   function automatic logic port_in(input logic [16:0] mask, input logic [4:0] p);
      port_in = (int'(p) < NUM_PORTS) ? mask[p] : 1'b0;
   endfunction

   // page select register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         page_q <= 8'h00;
      end else if (reg_wr && reg_addr == `SMM_OFF_PAGE) begin
         page_q <= reg_wdata[7:0];
      end
   end

   // management config; reserved bits held at zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q <= 8'h00;
      end else if (hit(`SMM_OFF_MGMT_CFG)) begin
         cfg_q <= reg_wdata[7:0] & `SMM_CFG_RW_MASK;
      end
   end

   // aging interval, any 20-bit value taken as written
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aging_q <= `SMM_AGING_RESET;
      end else if (hit(`SMM_OFF_AGING)) begin
         aging_q <= reg_wdata[19:0];
      end
   end

   // mirror capture control
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mir_en_q <= 1'b0;
         mir_blk_q <= 1'b0;
         cap_q <= 5'h00;
      end else if (hit(`SMM_OFF_MIR_CAP)) begin
         mir_en_q <= reg_wdata[`SMM_MIR_EN_BIT];
         mir_blk_q <= reg_wdata[`SMM_MIR_BLK_BIT];
         cap_q <= reg_wdata[4:0];
      end
   end

   // ingress and egress mirror selection
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         in_div_en_q <= 1'b0;
         in_mask_q <= 17'h00000;
         in_div_q <= 10'h000;
         eg_mask_q <= 17'h00000;
      end else begin
         if (hit(`SMM_OFF_IN_MIR)) begin
            in_div_en_q <= reg_wdata[`SMM_IN_DIV_EN_BIT];
            in_mask_q <= reg_wdata[16:0];
         end
         if (hit(`SMM_OFF_IN_DIV)) begin
            in_div_q <= reg_wdata[9:0];
         end
         if (hit(`SMM_OFF_EG_MIR)) begin
            eg_mask_q <= reg_wdata[16:0];
         end
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h00000000;
         if (reg_addr == `SMM_OFF_PAGE) begin
            reg_rdata <= {24'h000000, page_q};
         end else if (on_page) begin
            case (reg_addr)
               `SMM_OFF_MGMT_CFG: reg_rdata <= {24'h000000, cfg_q};
               `SMM_OFF_AGING: reg_rdata <= {12'h000, aging_q};
               `SMM_OFF_MIR_CAP: reg_rdata <= {16'h0000, mir_en_q, mir_blk_q, 9'h000, cap_q};
               `SMM_OFF_IN_MIR: reg_rdata <= {2'h0, in_div_en_q, 12'h000, in_mask_q};
               `SMM_OFF_IN_DIV: reg_rdata <= {22'h000000, in_div_q};
               `SMM_OFF_EG_MIR: reg_rdata <= {15'h0000, eg_mask_q};
               `SMM_OFF_MODEL: reg_rdata <= {24'h000000, MODEL_CODE};
               `SMM_OFF_REV: reg_rdata <= {24'h000000, REV_CODE};
               default: reg_rdata <= 32'h00000000; // unmapped reads zero
            endcase
         end
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // frame steering
   // ----------------------------------------
   logic imp_sel;
   logic rx_masked;
   logic div_hit;
   assign imp_sel = (cfg_q[`SMM_CFG_PORT_HI:`SMM_CFG_PORT_LO] == `SMM_PORT_SEL_IMP);
   assign rx_masked = rx_valid && port_in(in_mask_q, rx_port);
   // divider value 0 or 1 mirrors every frame; counter restarts at each hit
   assign div_hit = !in_div_en_q || (in_div_q <= 10'd1) || (div_cnt_q + 10'd1 >= in_div_q);

   // one-in-n counter over masked ingress frames
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt_q <= 10'h000;
      end else if (mir_en_q && rx_masked && in_div_en_q) begin
         div_cnt_q <= div_hit ? 10'h000 : div_cnt_q + 10'd1;
      end
   end

   // registered steering decisions, one cycle after the frame strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         to_cpu_q <= 1'b0;
         drop_bpdu_q <= 1'b0;
         mirror_rx_q <= 1'b0;
         mirror_tx_q <= 1'b0;
         block_dest_q <= 1'b0;
      end else begin
         // cpu copies need a valid port code, else nowhere to send them
         to_cpu_q <= rx_valid && imp_sel && ((cfg_q[`SMM_CFG_SNOOP_BIT] && rx_is_ip
                     && rx_ip_proto == `SMM_IGMP_PROTO)
                     || (cfg_q[`SMM_CFG_BPDU_BIT] && rx_is_bpdu));
         drop_bpdu_q <= rx_valid && rx_is_bpdu && !(cfg_q[`SMM_CFG_BPDU_BIT] && imp_sel);
         mirror_rx_q <= mir_en_q && rx_masked && div_hit;
         mirror_tx_q <= mir_en_q && tx_valid && port_in(eg_mask_q, tx_port);
         block_dest_q <= mir_blk_q && tx_valid && (tx_dest == cap_q);
      end
   end
   assign capture_port_q = cap_q;

   // ----------------------------------------
   // aging timer: one pulse every aging_q seconds plus two clocks
   // ----------------------------------------
   assign aging_active = (aging_q != 20'h00000);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         age_st_q <= SMM_AGE_IDLE;
         tick_cnt_q <= 32'h00000000;
         sec_cnt_q <= 20'h00000;
         age_tick_q <= 1'b0;
      end else begin
         age_tick_q <= 1'b0;
         case (age_st_q)
            SMM_AGE_IDLE: begin
               tick_cnt_q <= 32'h00000000;
               sec_cnt_q <= 20'h00000;
               if (aging_active) begin
                  age_st_q <= SMM_AGE_COUNT;
               end
            end
            SMM_AGE_COUNT: begin
               if (!aging_active) begin
                  age_st_q <= SMM_AGE_IDLE;
               end else if (tick_cnt_q == 32'(TICKS_PER_SEC - 1)) begin
                  tick_cnt_q <= 32'h00000000;
                  if (sec_cnt_q + 20'd1 >= aging_q) begin
                     age_st_q <= SMM_AGE_SWEEP;
                  end else begin
                     sec_cnt_q <= sec_cnt_q + 20'd1;
                  end
               end else begin
                  tick_cnt_q <= tick_cnt_q + 32'd1;
               end
            end
            SMM_AGE_SWEEP: begin
               age_tick_q <= 1'b1;
               sec_cnt_q <= 20'h00000;
               age_st_q <= SMM_AGE_IDLE;
            end
            default: age_st_q <= SMM_AGE_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_cfg_reset_zero: assert property (@(posedge sys_clk) rst |=> cfg_q == 8'h00)
      else $error("config not zero after reset");
   a_cpu_needs_imp: assert property (@(posedge sys_clk) disable iff (rst) to_cpu_q |-> $past(imp_sel))
      else $error("cpu copy without port code 10");
   a_snoop_proto: assert property (@(posedge sys_clk) disable iff (rst)
      (rx_valid && imp_sel && cfg_q[3] && rx_is_ip && rx_ip_proto == 8'h02) |=> to_cpu_q)
      else $error("igmp frame not sent to cpu");
   a_bpdu_blocked: assert property (@(posedge sys_clk) disable iff (rst)
      (rx_valid && rx_is_bpdu && !cfg_q[1]) |=> drop_bpdu_q)
      else $error("bpdu delivered while disabled");
   a_bpdu_to_cpu: assert property (@(posedge sys_clk) disable iff (rst)
      (rx_valid && rx_is_bpdu && cfg_q[1] && imp_sel) |=> to_cpu_q && !drop_bpdu_q)
      else $error("enabled bpdu not sent to cpu");
   a_age_reset: assert property (@(posedge sys_clk) rst |=> aging_q == 20'd300)
      else $error("aging reset value wrong");
   a_age_stopped: assert property (@(posedge sys_clk) disable iff (rst)
      (aging_q == 20'h0) [*3] |-> !age_tick_q)
      else $error("aging tick while disabled");
   a_mirror_off: assert property (@(posedge sys_clk) disable iff (rst)
      !mir_en_q |=> !mirror_rx_q && !mirror_tx_q)
      else $error("mirror while disabled");
   a_ingress_mask: assert property (@(posedge sys_clk) disable iff (rst)
      (mir_en_q && rx_valid && rx_port == 5'd0 && in_mask_q[0] && !in_div_en_q) |=> mirror_rx_q)
      else $error("ingress port 0 not mirrored");
   a_egress_mask: assert property (@(posedge sys_clk) disable iff (rst)
      (mir_en_q && tx_valid && tx_port == 5'd0 && eg_mask_q[0]) |=> mirror_tx_q)
      else $error("egress port 0 not mirrored");
   a_blk_dest: assert property (@(posedge sys_clk) disable iff (rst)
      block_dest_q |-> $past(mir_blk_q) && $past(tx_dest) == $past(cap_q))
      else $error("block without cause");
   a_page_gate: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && !on_page && reg_addr == 8'h00) |=> $stable(cfg_q))
      else $error("write off page reached config");
   c_rx_mirror: cover property (@(posedge sys_clk) mirror_rx_q);
   c_cpu_copy: cover property (@(posedge sys_clk) to_cpu_q);
   c_age_tick: cover property (@(posedge sys_clk) age_tick_q);
   c_blocked: cover property (@(posedge sys_clk) block_dest_q);
endmodule

//--- tb/smm_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// management cpu on the register port
// ----------------------------------------
module smm_cpu_model (
   input wire logic sys_clk, // core clock
   output logic [7:0] reg_addr, // register offset
   output logic [31:0] reg_wdata, // write data
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   input wire logic [31:0] reg_rdata // read data
);
   // quiet bus from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one-cycle write; data is scrambled afterwards so stale data is never trusted
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   endtask
   // one-cycle read; data stands only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
   endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int TPS = 4; // a second shortened to four clocks
   logic sys_clk, rst, reg_wr, reg_rd, rx_valid, rx_is_ip, rx_is_bpdu, tx_valid, en, blk;
   logic [7:0] reg_addr, rx_ip_proto;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [4:0] rx_port, tx_port, tx_dest, cap, p;
   logic to_cpu_q, drop_bpdu_q, mirror_rx_q, mirror_tx_q, block_dest_q, age_tick_q, aging_active;
   smm_pkg::smm_port_t capture_port_q;
   logic [16:0] im, em;
   int error_cnt, comparisons, n;

   smm_mgmt_page #(.TICKS_PER_SEC(TPS)) dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .rx_valid, .rx_port, .rx_ip_proto, .rx_is_ip, .rx_is_bpdu, .tx_valid, .tx_port, .tx_dest,
      .to_cpu_q, .drop_bpdu_q, .mirror_rx_q, .mirror_tx_q, .capture_port_q, .block_dest_q, .age_tick_q,
      .aging_active);
   smm_cpu_model cpu_u (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

   // 10 MHz core clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic exp_mir(input logic e, input logic [16:0] m, input logic [4:0] pt);
      return e & m[pt];
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // steering outputs are looked at in the cycle after the descriptor
   task automatic rx(input logic [4:0] pt, input logic [7:0] pr, input logic bp);
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_port <= pt;
      rx_ip_proto <= pr;
      rx_is_bpdu <= bp;
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      #1;
   endtask
   task automatic tx(input logic [4:0] pt, input logic [4:0] ds);
      @(posedge sys_clk);
      tx_valid <= 1'b1;
      tx_port <= pt;
      tx_dest <= ds;
      @(posedge sys_clk);
      tx_valid <= 1'b0;
      #1;
   endtask
   // bounded wait for the aging pulse; running out ends the run
   task automatic wait_tick(input int lim);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (age_tick_q !== 1'b1 && n < lim);
      if (n >= lim) begin
         error_cnt++;
         end_of_test();
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      {rx_valid, rx_is_bpdu, tx_valid} = 3'h0;
      rx_is_ip = 1'b1;
      {rx_port, tx_port, tx_dest, rx_ip_proto} = 23'h0;
      void'($urandom(35864));
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      // off the page nothing reads back and a config write is lost
      cpu_u.rd(8'h0c, d);
      check(d, 32'h0);
      cpu_u.wr(8'h00, 32'hff);
      cpu_u.wr(8'hff, 32'h02);
      cpu_u.rd(8'h00, d);
      check(d, 32'h0);
      cpu_u.rd(8'h0c, d);
      check(d, 32'h12c);
      cpu_u.rd(8'h10, d);
      check(d, 32'h0);
      check(capture_port_q, 5'h0);
      cpu_u.rd(8'h20, d);
      check(d, 32'h0);
      cpu_u.wr(8'h00, 32'hff);
      cpu_u.rd(8'h00, d);
      check(d, 32'hca);
      // every selector code with snooping on: only code 10 reaches the cpu port
      for (int s = 0; s < 4; s++) begin
         cpu_u.wr(8'h00, {24'h0, 2'(s), 6'h08});
         rx(5'h3, 8'h02, 1'b0);
         check(to_cpu_q, s == 2);
      end
      // valid selector, so only the protocol field or a cleared snoop bit keeps the frame away
      cpu_u.wr(8'h00, 32'h88);
      rx(5'h3, 8'h11, 1'b0);
      check(to_cpu_q, 1'b0);
      cpu_u.wr(8'h00, 32'h80);
      rx(5'h3, 8'h02, 1'b0);
      check(to_cpu_q, 1'b0);
      rx(5'h5, 8'h00, 1'b1);
      check(drop_bpdu_q, 1'b1);
      cpu_u.wr(8'h00, 32'h82);
      rx(5'h5, 8'h00, 1'b1);
      check(drop_bpdu_q, 1'b0);
      check(to_cpu_q, 1'b1);
      // leaving the page blocks writes; the config survives the return
      cpu_u.wr(8'hff, 32'h01);
      cpu_u.wr(8'h00, 32'hff);
      cpu_u.wr(8'hff, 32'h02);
      cpu_u.rd(8'h00, d);
      check(d, 32'h82);
      // aging: period, full width, and stop at zero
      cpu_u.wr(8'h0c, 32'h3);
      wait_tick(2000);
      wait_tick(200);
      check(n, 3 * TPS + 2);
      cpu_u.wr(8'h0c, 32'hffffffff);
      cpu_u.rd(8'h0c, d);
      check(d, 32'h000fffff);
      cpu_u.wr(8'h0c, 32'h0);
      cpu_u.rd(8'h0c, d);
      check(d, 32'h0);
      check(aging_active, 1'b0);
      n = 0;
      repeat (100) begin
         @(posedge sys_clk);
         #1;
         if (age_tick_q !== 1'b0) n++;
      end
      check(n, 0);
      cpu_u.wr(8'h10, 32'hffff);
      cpu_u.rd(8'h10, d);
      check(d, 32'hc01f);
      check(capture_port_q, 5'h1f);
      // random mirror settings, ports and destinations
      for (int i = 0; i < 24; i++) begin
         {en, blk} = 2'($urandom);
         cap = 5'($urandom_range(0, 16));
         im = 17'($urandom);
         em = 17'($urandom);
         p = 5'($urandom_range(0, 16));
         cpu_u.wr(8'h10, {16'h0, en, blk, 9'h0, cap});
         cpu_u.wr(8'h12, {15'h0, im});
         cpu_u.wr(8'h1c, {15'h0, em});
         check(capture_port_q, cap);
         rx(p, 8'h06, 1'b0);
         check(mirror_rx_q, exp_mir(en, im, p));
         tx(p, i[0] ? cap : cap ^ 5'h01);
         check(mirror_tx_q, exp_mir(en, em, p));
         check(block_dest_q, blk & i[0]);
      end
      // divider of three: six masked frames give two copies
      cpu_u.wr(8'h10, 32'h8000);
      cpu_u.wr(8'h12, 32'h20000001);
      cpu_u.rd(8'h12, d);
      check(d, 32'h20000001);
      cpu_u.wr(8'h16, 32'h3);
      cpu_u.rd(8'h16, d);
      check(d, 32'h3);
      n = 0;
      repeat (6) begin
         rx(5'h0, 8'h06, 1'b0);
         if (mirror_rx_q === 1'b1) n++;
      end
      check(n, 2);
      // port 0 corner cases, normal destination away from the capture port
      cpu_u.wr(8'h12, 32'h1);
      rx(5'h0, 8'h06, 1'b0);
      check(mirror_rx_q, 1'b1);
      cpu_u.wr(8'h1c, 32'h1);
      tx(5'h0, 5'h1);
      check(mirror_tx_q, 1'b1);
      check(block_dest_q, 1'b0);
      end_of_test();
   end
endmodule
